// File: cfh_pkg.sv
// Package with offsets, field layouts, reset values and timing for cfh.
package cfh_pkg;

  // Register offsets on the host register port.
  localparam logic [7:0] ADDR_DEVICE_SETUP = 8'h01;
  localparam logic [7:0] ADDR_HEALTH       = 8'h02;

  // Setup register field positions.
  localparam int SETUP_PEC_BIT    = 0;
  localparam int SETUP_MAP_BIT    = 1;
  localparam int SETUP_RELOAD_BIT = 2;
  localparam int SETUP_USED_BITS  = 3;

  // Health register field positions.
  localparam int HEALTH_UV_BIT  = 0;
  localparam int HEALTH_OV_BIT  = 1;
  localparam int HEALTH_PRIM_EN_BIT = 2;
  localparam int HEALTH_SEC_EN_BIT  = 3;
  localparam int HEALTH_RST_BIT     = 4;
  localparam int HEALTH_RFF_BIT     = 5;
  localparam int HEALTH_PARITY_BIT  = 6;
  localparam int HEALTH_OSC_BIT     = 7;

  // Values held before the one-time-programmed defaults are loaded.
  localparam logic [7:0] SETUP_RESET  = 8'h00;
  localparam logic [7:0] HEALTH_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET  = 8'h00;

  // Self-test timing at the 250 MHz core clock.
  localparam int CLK_PERIOD_NS       = 4;
  localparam int SELFTEST_TYP_NS     = 60000;
  localparam int SELFTEST_MAX_NS     = 72200;
  localparam int SELFTEST_TYP_CYCLES = SELFTEST_TYP_NS / CLK_PERIOD_NS;
  localparam int SELFTEST_MAX_CYCLES = SELFTEST_MAX_NS / CLK_PERIOD_NS;
  localparam int SELFTEST_CNT_W      = 15;

  // Setup register layout.
  typedef struct packed {
    logic [4:0] unused;
    logic       reload_select;
    logic       selftest_fail_to_reset_map;
    logic       packet_check_enable;
  } cfh_setup_t;

  // Health and pin status register layout.
  typedef struct packed {
    logic oscillator_fault;
    logic parity_fault;
    logic reset_fault_flag;
    logic reset_pin;
    logic secondary_enable;
    logic primary_enable;
    logic overvoltage_selftest_status;
    logic undervoltage_selftest_status;
  } cfh_health_t;

  // Self-test sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE
  } cfh_st_state_t;

endpackage

// File: cfh_config_health.sv
// Setup and health status register pair of the power-system monitor.
// Function
// - Reload defaults on enable fall after recording.
// - Reload select also reloads on watchdog reset.
// - Mapping bit routes self-test failures to reset.
// - Bit zero turns packet error checking on.
// - Self-test runs after undervoltage lockout release.
// - Bit seven reports oscillator fault.
// - Bit six reports register parity fault.
// - Bit five flags any reset-causing fault.
// - Bit four reads back the reset pin.
// - Bit three reads back secondary enable.
// - Bit two reads back primary enable.
// - Bit one reports overvoltage self-test failure.
// - Bit zero reports undervoltage self-test failure.
module cfh_config_health #(
  parameter int SELFTEST_CYCLES = cfh_pkg::SELFTEST_TYP_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Host register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // One-time-programmed default of the setup bits.
  input  wire logic [2:0] otp_setup_default,
  // Pins and fault sources.
  input  wire logic       primary_enable_pin,
  input  wire logic       secondary_enable_pin,
  input  wire logic       reset_pin_level,
  input  wire logic       seq_record_done,
  input  wire logic       watchdog_reset_event,
  input  wire logic       other_reset_fault,
  input  wire logic       osc_fault_in,
  input  wire logic       parity_fault_in,
  input  wire logic       supply_above_uvlo,
  input  wire logic       ov_cmp_fail,
  input  wire logic       uv_cmp_fail,
  // Outputs to the rest of the device.
  output logic            packet_check_enable,
  output logic            reset_assert,
  output logic            otp_reload_strobe,
  output logic            selftest_busy
);

  logic                  rst_meta_n;
  logic                  rst_sync_n;
  cfh_pkg::cfh_setup_t   setup_reg;
  cfh_pkg::cfh_setup_t   setup_next;
  cfh_pkg::cfh_health_t  health_reg;
  cfh_pkg::cfh_health_t  health_next;
  cfh_pkg::cfh_st_state_t st_state_reg;
  cfh_pkg::cfh_st_state_t st_state_next;
  logic [cfh_pkg::SELFTEST_CNT_W-1:0] st_cnt_reg;
  logic                  load_pending_reg;
  logic                  reload_armed_reg;
  logic                  prim_en_q_reg;
  logic                  uvlo_q_reg;
  logic                  st_ov_reg;
  logic                  st_uv_reg;
  logic                  rdata_valid_next;
  logic [7:0]            rdata_next;

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Decode of host accesses and reload causes.
  wire sel_setup   = reg_addr == cfh_pkg::ADDR_DEVICE_SETUP;
  wire sel_health  = reg_addr == cfh_pkg::ADDR_HEALTH;
  wire setup_wr    = reg_wr_en && sel_setup;
  wire prim_fall   = prim_en_q_reg && !primary_enable_pin;
  wire reload_seq  = reload_armed_reg && seq_record_done;
  wire reload_wd   = setup_reg.reload_select
                     && watchdog_reset_event;
  wire reload_now  = load_pending_reg || reload_seq || reload_wd;
  wire uvlo_rise   = supply_above_uvlo && !uvlo_q_reg;
  wire st_finish   = st_state_reg == cfh_pkg::ST_RUN &&
                     st_cnt_reg == SELFTEST_CYCLES[cfh_pkg::SELFTEST_CNT_W-1:0]
                     - 15'h0001;
  wire st_fail_map = setup_reg.selftest_fail_to_reset_map
                     && (st_ov_reg || st_uv_reg);
  wire rst_fault   = other_reset_fault || st_fail_map;

  // Setup register next value: reload wins over a host write.
  always_comb begin
    setup_next = setup_reg;
    if (reload_now) begin
      setup_next = cfh_pkg::cfh_setup_t'({5'h00, otp_setup_default});
    end else if (setup_wr) begin
      // Only the three defined bits are stored.
      setup_next = cfh_pkg::cfh_setup_t'({5'h00,
                   reg_wdata[cfh_pkg::SETUP_USED_BITS-1:0]});
    end
  end

  // Health register assembled from sampled pins and fault sources.
  always_comb begin
    health_next                              = health_reg;
    health_next.oscillator_fault             = osc_fault_in;
    health_next.parity_fault                 = parity_fault_in;
    health_next.reset_fault_flag             = rst_fault;
    health_next.reset_pin                    = reset_pin_level;
    health_next.secondary_enable             =
      secondary_enable_pin;
    health_next.primary_enable               = primary_enable_pin;
    health_next.overvoltage_selftest_status  = st_ov_reg;
    health_next.undervoltage_selftest_status = st_uv_reg;
  end

  // Self-test sequencer: restarts on every lockout release.
  always_comb begin
    st_state_next = st_state_reg;
    case (st_state_reg)
      cfh_pkg::ST_IDLE: begin
        if (uvlo_rise) begin
          st_state_next = cfh_pkg::ST_RUN;
        end
      end
      cfh_pkg::ST_RUN: begin
        if (st_finish) begin
          st_state_next = cfh_pkg::ST_DONE;
        end
      end
      cfh_pkg::ST_DONE: begin
        if (uvlo_rise) begin
          st_state_next = cfh_pkg::ST_RUN;
        end
      end
      default: begin
        st_state_next = cfh_pkg::ST_IDLE;
      end
    endcase
  end

  // Read data selection; unmapped addresses read as zero.
  always_comb begin
    rdata_valid_next = reg_rd_en;
    rdata_next       = cfh_pkg::RDATA_RESET;
    if (reg_rd_en && sel_setup) begin
      rdata_next = setup_reg;
    end else if (reg_rd_en && sel_health) begin
      rdata_next = health_reg;
    end
  end

  // Control and status registers.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      setup_reg        <= cfh_pkg::cfh_setup_t'(cfh_pkg::SETUP_RESET);
      health_reg       <= cfh_pkg::cfh_health_t'(cfh_pkg::HEALTH_RESET);
      load_pending_reg <= 1'b1;
      reload_armed_reg <= 1'b0;
      prim_en_q_reg    <= 1'b0;
      uvlo_q_reg       <= 1'b0;
      otp_reload_strobe <= 1'b0;
    end else begin
      setup_reg        <= setup_next;
      health_reg       <= health_next;
      load_pending_reg <= 1'b0;
      reload_armed_reg <= prim_fall || (reload_armed_reg && !reload_seq);
      prim_en_q_reg    <= primary_enable_pin;
      uvlo_q_reg       <= supply_above_uvlo;
      otp_reload_strobe <= reload_now;
    end
  end

  // Self-test counter and captured results.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_state_reg  <= cfh_pkg::ST_IDLE;
      st_cnt_reg    <= '0;
      st_ov_reg     <= 1'b0;
      st_uv_reg     <= 1'b0;
      selftest_busy <= 1'b0;
    end else begin
      st_state_reg  <= st_state_next;
      st_cnt_reg    <= (st_state_next == cfh_pkg::ST_RUN && !uvlo_rise)
                       ? st_cnt_reg + 15'h0001 : '0;
      selftest_busy <= st_state_next == cfh_pkg::ST_RUN;
      if (st_finish) begin
        st_ov_reg <= ov_cmp_fail;
        st_uv_reg <= uv_cmp_fail;
      end
    end
  end

  // Host read port outputs, packet check enable and reset request.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata           <= cfh_pkg::RDATA_RESET;
      reg_rd_valid        <= 1'b0;
      packet_check_enable <= 1'b0;
      reset_assert        <= 1'b0;
    end else begin
      reg_rdata           <= rdata_next;
      reg_rd_valid        <= rdata_valid_next;
      packet_check_enable <= setup_next.packet_check_enable;
      reset_assert        <= rst_fault;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  AST_RELOAD_SEQ: assert property (
    (reload_armed_reg && seq_record_done) |=> otp_reload_strobe
      && setup_reg[2:0] == $past(otp_setup_default)
  ) else $error("No reload after enable fall and recording done.");

  AST_ARM: assert property (
    prim_fall |=> reload_armed_reg
  ) else $error("Enable fall did not arm the reload.");

  AST_RELOAD_WD: assert property (
    (setup_reg.reload_select && watchdog_reset_event) |=> otp_reload_strobe
      && setup_reg[2:0] == $past(otp_setup_default)
  ) else $error("No reload after watchdog reset.");

  AST_MAP: assert property (
    (setup_reg.selftest_fail_to_reset_map && st_ov_reg) |=> reset_assert
  ) else $error("Mapped self-test failure did not assert reset.");

  AST_PEC: assert property (
    (setup_wr && !reload_now) |=> packet_check_enable == $past(reg_wdata[0])
  ) else $error("Packet check enable does not follow the write.");

  AST_ST_LEN: assert property (
    st_cnt_reg < 15'(cfh_pkg::SELFTEST_MAX_CYCLES)
  ) else $error("Self-test exceeded its longest time.");

  AST_ST_CAPTURE: assert property (
    st_finish |=> st_state_reg == cfh_pkg::ST_DONE
      && st_ov_reg == $past(ov_cmp_fail) && st_uv_reg == $past(uv_cmp_fail)
  ) else $error("Self-test results not captured at completion.");

  AST_OSC_PAR: assert property (
    (osc_fault_in && !parity_fault_in) |=> health_reg.oscillator_fault
      && !health_reg.parity_fault
  ) else $error("Oscillator or parity fault bit wrong.");

  AST_PARITY: assert property (
    parity_fault_in |=> health_reg.parity_fault
  ) else $error("Parity fault bit not set.");

  AST_RFF: assert property (
    health_reg.reset_fault_flag == reset_assert
  ) else $error("Reset fault flag differs from reset request.");

  AST_PINS: assert property (
    ##1 {health_reg.reset_pin, health_reg.secondary_enable,
         health_reg.primary_enable} ==
        $past({reset_pin_level, secondary_enable_pin, primary_enable_pin})
  ) else $error("Pin readback does not match sampled pins.");

  AST_RO: assert property (
    (reg_wr_en && sel_health && !reload_now && !st_finish) |=>
      $stable(setup_reg) && $stable(st_ov_reg) && $stable(st_uv_reg)
  ) else $error("Write disturbed read-only state.");

endmodule

// File: cfh_host_model.sv
// Host controller model driving the setup and health register port.
module cfh_host_model (
  // Clock.
  input  wire logic       clk,
  // Register port towards the block.
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobes idle low from time zero.
  initial begin
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  // One write held over its taking edge; released lines show junk after.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // One read; returns the valid flag above the read data.
  task automatic rd(input logic [7:0] a, output logic [8:0] v);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    v         = {reg_rd_valid, reg_rdata};
  endtask
endmodule

// File: cfh_config_health_bench.sv
// Self-checking bench for the setup and health register pair.
module cfh_config_health_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST_CYC = 20;
  // Table row: write data, pins {osc, parity, reset, second, primary},
  // then the expected setup and health reads.
  typedef struct packed {
    logic [7:0] wd;
    logic [4:0] pins;
    logic [7:0] setup;
    logic [7:0] health;
  } cfh_row_t;
  localparam cfh_row_t ROWS [4] = '{
    '{8'hff, 5'h1f, 8'h07, 8'hdc}, '{8'h00, 5'h00, 8'h00, 8'h00},
    '{8'hfa, 5'h15, 8'h02, 8'h94}, '{8'h0d, 5'h0a, 8'h05, 8'h48}};
  logic       clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic       seq_record_done, watchdog_reset_event, other_reset_fault;
  logic       osc_fault_in, parity_fault_in, reset_pin_level;
  logic       secondary_enable_pin, primary_enable_pin, supply_above_uvlo;
  logic       ov_cmp_fail, uv_cmp_fail, packet_check_enable, reset_assert;
  logic       otp_reload_strobe, selftest_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] otp_setup_default;
  logic [8:0] v;
  int         err_total = 0;
  int         checked = 0;
  int         cyc = 0;
  int         n;

  cfh_config_health #(.SELFTEST_CYCLES(ST_CYC)) u_cfh_config_health (
    .clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .reg_rd_valid, .otp_setup_default, .primary_enable_pin,
    .secondary_enable_pin, .reset_pin_level, .seq_record_done,
    .watchdog_reset_event, .other_reset_fault, .osc_fault_in,
    .parity_fault_in, .supply_above_uvlo, .ov_cmp_fail, .uv_cmp_fail,
    .packet_check_enable, .reset_assert, .otp_reload_strobe, .selftest_busy);
  cfh_host_model u_cfh_host_model (
    .clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .reg_rd_valid);

  // Clock at 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard well above the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // Compare and report.
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read a register and expect a valid answer with the given data.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_cfh_host_model.rd(a, v);
    chk(v, {1'b1, e});
  endtask

  // Let some edges pass and land just after the last one.
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Verdict and end of run.
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset, table, then hand-written cases.
  initial begin
    {rst_n, seq_record_done, watchdog_reset_event, other_reset_fault} = '0;
    {supply_above_uvlo, ov_cmp_fail, uv_cmp_fail} = '0;
    {osc_fault_in, parity_fault_in, reset_pin_level, secondary_enable_pin,
     primary_enable_pin} = '0;
    otp_setup_default = 3'h5;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    wait_cyc(5);
    rdchk(8'h01, 8'h05);
    chk({8'h00, packet_check_enable}, 9'h001);
    foreach (ROWS[i]) begin
      {osc_fault_in, parity_fault_in, reset_pin_level, secondary_enable_pin,
       primary_enable_pin} = ROWS[i].pins;
      u_cfh_host_model.wr(8'h01, ROWS[i].wd);
      rdchk(8'h01, ROWS[i].setup);
      chk({8'h00, packet_check_enable}, {8'h00, ROWS[i].setup[0]});
      rdchk(8'h02, ROWS[i].health);
    end
    // Read-only write and unmapped read.
    u_cfh_host_model.wr(8'h02, 8'hff);
    rdchk(8'h02, 8'h48);
    rdchk(8'h07, 8'h00);
    // Other fault raises the flag and the reset request.
    other_reset_fault = 1'b1;
    wait_cyc(2);
    rdchk(8'h02, 8'h68);
    chk({8'h00, reset_assert}, 9'h001);
    other_reset_fault = 1'b0;
    // Self-test with an overvoltage failure; busy length is timed.
    ov_cmp_fail = 1'b1;
    supply_above_uvlo = 1'b1;
    n = 0;
    wait_cyc(2);
    while (selftest_busy === 1'b1 && n < 100) begin
      wait_cyc(1);
      n++;
    end
    chk({8'h00, n >= ST_CYC - 3 && n <= ST_CYC + 1}, 9'h001);
    rdchk(8'h02, 8'h4a);
    // Mapping bit routes the failure to reset, and clearing it does not.
    u_cfh_host_model.wr(8'h01, 8'h02);
    wait_cyc(1);
    chk({8'h00, reset_assert}, 9'h001);
    rdchk(8'h02, 8'h6a);
    u_cfh_host_model.wr(8'h01, 8'h00);
    wait_cyc(1);
    chk({8'h00, reset_assert}, 9'h000);
    // Retriggered self-test with an undervoltage failure.
    {supply_above_uvlo, ov_cmp_fail, uv_cmp_fail} = 3'h1;
    wait_cyc(2);
    supply_above_uvlo = 1'b1;
    wait_cyc(ST_CYC + 5);
    rdchk(8'h02, 8'h49);
    // Watchdog reload with the select bit set, ignored with it clear.
    otp_setup_default = 3'h3;
    u_cfh_host_model.wr(8'h01, 8'h04);
    watchdog_reset_event = 1'b1;
    wait_cyc(1);
    chk({8'h00, otp_reload_strobe}, 9'h001);
    watchdog_reset_event = 1'b0;
    rdchk(8'h01, 8'h03);
    u_cfh_host_model.wr(8'h01, 8'h01);
    watchdog_reset_event = 1'b1;
    wait_cyc(1);
    chk({8'h00, otp_reload_strobe}, 9'h000);
    watchdog_reset_event = 1'b0;
    rdchk(8'h01, 8'h01);
    // Enable fall reloads only once recording has finished.
    otp_setup_default = 3'h6;
    u_cfh_host_model.wr(8'h01, 8'h00);
    primary_enable_pin = 1'b1;
    wait_cyc(2);
    primary_enable_pin = 1'b0;
    wait_cyc(3);
    rdchk(8'h01, 8'h00);
    seq_record_done = 1'b1;
    wait_cyc(2);
    rdchk(8'h01, 8'h06);
    chk({8'h00, otp_reload_strobe}, 9'h000);
    tally_and_finish();
  end
endmodule
